// ==== src/pmad_pkg.sv ====
/*
 * package for the bus address strap decoder: bin thresholds, fallback address, state types.
 * assumes a 12-bit converter whose result is presented as a one-cycle valid with a pin select.
 */
package pmad_pkg;

    localparam int unsigned adc_w = 12;
    localparam int unsigned addr_w = 7;
    localparam int unsigned bin_count = 8;

    // bin index arithmetic and fallback address
    localparam logic [3:0] bin_first = 4'h4;
    localparam logic [3:0] addr_mult = 4'hC;
    localparam logic [6:0] fallback_addr = 7'h7E;

    // nine code boundaries bracket eight bins; ratio 1.25 between steps.
    // boundary k is the lowest code of bin (4+k); boundary 8 is top of bin 11.
    // values assume bias current into 31.6k..200k full scale; they are parameters below.
    localparam logic [11:0] thr_b0 = 12'h0_1B5;
    localparam logic [11:0] thr_b1 = 12'h0_222;
    localparam logic [11:0] thr_b2 = 12'h0_2AB;
    localparam logic [11:0] thr_b3 = 12'h0_355;
    localparam logic [11:0] thr_b4 = 12'h0_42B;
    localparam logic [11:0] thr_b5 = 12'h0_535;
    localparam logic [11:0] thr_b6 = 12'h0_683;
    localparam logic [11:0] thr_b7 = 12'h0_823;
    localparam logic [11:0] thr_b8 = 12'h0_A2C;

    localparam logic pin_lower = 1'b0;
    localparam logic pin_upper = 1'b1;

    typedef enum logic [2:0] {
        pmad_req_lower,
        pmad_wait_lower,
        pmad_req_upper,
        pmad_wait_upper,
        pmad_done
    } pmad_state_e;

    typedef struct packed {
        logic [6:0] addr;
        logic jtag_en;
        logic valid;
    } pmad_result_s;

    typedef struct packed {
        pmad_state_e st;
        logic [3:0] bin_lower;
        logic bad;
        logic flash_blank;
        pmad_result_s res;
        logic gpio_en;
        logic bias_en;
        logic conv_start;
        logic conv_sel;
    } pmad_state_s;

endpackage : pmad_pkg

// ==== src/pmad_decode.sv ====
/*
 * bus address strap decoder: converts both address-detect pins once after reset and
 * holds the address and the jtag enable until the next reset.
 * assumes an on-chip converter answering conv_start with one conv_valid pulse and the code,
 * and a flash status level that is stable at reset release.
 */
// Function
// - bias both pins, convert each with the 12-bit converter before deciding
// - address is twelve times upper bin plus lower bin
// - each reading maps to bins 4..11, thresholds stepping by 1.25
// - a reading below the lowest bin forces address 126
// - a reading above the highest bin forces address 126
// - fallback address enables jtag and blocks shared pins as gpio
// - blank configuration flash also enables jtag at power-up
module pmad_decode #(
    parameter logic [11:0] thr_0 = pmad_pkg::thr_b0,
    parameter logic [11:0] thr_1 = pmad_pkg::thr_b1,
    parameter logic [11:0] thr_2 = pmad_pkg::thr_b2,
    parameter logic [11:0] thr_3 = pmad_pkg::thr_b3,
    parameter logic [11:0] thr_4 = pmad_pkg::thr_b4,
    parameter logic [11:0] thr_5 = pmad_pkg::thr_b5,
    parameter logic [11:0] thr_6 = pmad_pkg::thr_b6,
    parameter logic [11:0] thr_7 = pmad_pkg::thr_b7,
    parameter logic [11:0] thr_8 = pmad_pkg::thr_b8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flash_blank,
    input wire logic conv_valid,
    input wire logic [11:0] conv_code,
    output logic bias_en,
    output logic conv_start,
    output logic conv_sel,
    output logic [6:0] bus_addr,
    output logic jtag_en,
    output logic gpio_shared_en,
    output logic addr_valid
);

    typedef struct packed {
        logic oor;
        logic [3:0] bin;
    } pmad_bin_s;

    localparam logic [11:0] thr [0:8] = '{thr_0, thr_1, thr_2, thr_3, thr_4,
                                          thr_5, thr_6, thr_7, thr_8};

    // highest bin index, seven bins up from the first
    localparam logic [3:0] bin_last = pmad_pkg::bin_first + 4'(pmad_pkg::bin_count - 1);

    pmad_pkg::pmad_state_s cur;
    pmad_pkg::pmad_state_s nxt;

    // used for both pins, so one function
    function automatic pmad_bin_s classify(input logic [11:0] code);
        pmad_bin_s r;
        r.oor = (code < thr[0]) || (code > thr[8]);
        r.bin = pmad_pkg::bin_first;
        for (int k = 1; k < pmad_pkg::bin_count; k++)
        begin
            if (code >= thr[k])
            begin
                r.bin = pmad_pkg::bin_first + 4'(k);
            end
        end
        return r;
    endfunction : classify

    pmad_bin_s cls;
    logic [6:0] formed;
    logic fallback;
    logic jtag_pick;

    always_comb
    begin
        cls = classify(conv_code);
        // limitation: sums above 127 wrap; straps must stay clear of them
        formed = 7'(cur.bin_lower) + 7'(cls.bin) * 7'(pmad_pkg::addr_mult);
        // either pin out of range takes the fallback
        fallback = cur.bad || cls.oor;
        jtag_pick = fallback || cur.flash_blank;
        nxt = cur;
        nxt.conv_start = 1'b0;
        case (cur.st)
            pmad_pkg::pmad_req_lower:
            begin
                nxt.bias_en = 1'b1;
                nxt.conv_start = 1'b1;
                nxt.conv_sel = pmad_pkg::pin_lower;
                // sampled once; later flash writes must not reopen jtag
                nxt.flash_blank = flash_blank;
                nxt.st = pmad_pkg::pmad_wait_lower;
            end
            pmad_pkg::pmad_wait_lower:
            begin
                if (conv_valid)
                begin
                    nxt.bin_lower = cls.bin;
                    nxt.bad = cls.oor;
                    nxt.st = pmad_pkg::pmad_req_upper;
                end
            end
            pmad_pkg::pmad_req_upper:
            begin
                nxt.conv_start = 1'b1;
                nxt.conv_sel = pmad_pkg::pin_upper;
                nxt.st = pmad_pkg::pmad_wait_upper;
            end
            pmad_pkg::pmad_wait_upper:
            begin
                if (conv_valid)
                begin
                    if (fallback)
                    begin
                        nxt.res.addr = pmad_pkg::fallback_addr;
                    end
                    else
                    begin
                        nxt.res.addr = formed;
                    end
                    nxt.res.jtag_en = jtag_pick;
                    // own flop so the pin mux never sees a decode glitch
                    nxt.gpio_en = !jtag_pick;
                    nxt.res.valid = 1'b1;
                    nxt.bias_en = 1'b0;
                    nxt.st = pmad_pkg::pmad_done;
                end
            end
            pmad_pkg::pmad_done:
            begin
                nxt.st = pmad_pkg::pmad_done;
            end
            default:
            begin
                nxt.st = pmad_pkg::pmad_req_lower;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.st <= pmad_pkg::pmad_req_lower;
            // jtag stays on until the decision is known; pins stay out of gpio use
            cur.res.jtag_en <= 1'b1;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign bias_en = cur.bias_en;
    assign conv_start = cur.conv_start;
    assign conv_sel = cur.conv_sel;
    assign bus_addr = cur.res.addr;
    assign jtag_en = cur.res.jtag_en;
    assign gpio_shared_en = cur.gpio_en;
    assign addr_valid = cur.res.valid;

    a_fallback_jtag: assert property (@(posedge clock) disable iff (rst)
        addr_valid && bus_addr == pmad_pkg::fallback_addr |-> jtag_en && !gpio_shared_en)
        else $error("fallback address without jtag");
    a_valid_holds: assert property (@(posedge clock) disable iff (rst)
        addr_valid |=> addr_valid && $stable(bus_addr) && $stable(jtag_en))
        else $error("decoded result changed after valid");
    a_addr_formula: assert property (@(posedge clock) disable iff (rst)
        cur.st == pmad_pkg::pmad_wait_upper && conv_valid && !cur.bad && !cls.oor
        |=> bus_addr == 7'(cur.bin_lower) + 7'($past(cls.bin)) * 7'(pmad_pkg::addr_mult))
        else $error("address formula wrong");
    a_low_fallback: assert property (@(posedge clock) disable iff (rst)
        cur.st == pmad_pkg::pmad_wait_upper && conv_valid && conv_code < thr_0
        |=> bus_addr == pmad_pkg::fallback_addr)
        else $error("short not forcing fallback");
    a_high_fallback: assert property (@(posedge clock) disable iff (rst)
        cur.st == pmad_pkg::pmad_wait_upper && conv_valid && conv_code > thr_8
        |=> bus_addr == pmad_pkg::fallback_addr)
        else $error("open not forcing fallback");
    a_bin_range: assert property (@(posedge clock) disable iff (rst)
        conv_valid |-> cls.bin >= pmad_pkg::bin_first && cls.bin <= bin_last)
        else $error("bin out of 4..11");
    a_bin_top: assert property (@(posedge clock) disable iff (rst)
        conv_valid && conv_code >= thr_7 && conv_code <= thr_8 |-> cls.bin == bin_last)
        else $error("top bin misclassified");
    a_bin_bottom: assert property (@(posedge clock) disable iff (rst)
        conv_valid && conv_code >= thr_0 && conv_code < thr_1
        |-> cls.bin == pmad_pkg::bin_first)
        else $error("bottom bin misclassified");
    a_blank_jtag: assert property (@(posedge clock) disable iff (rst)
        addr_valid && cur.flash_blank |-> jtag_en)
        else $error("blank flash without jtag");
    a_flash_once: assert property (@(posedge clock) disable iff (rst)
        cur.st != pmad_pkg::pmad_req_lower |=> $stable(cur.flash_blank))
        else $error("flash status resampled");
    a_gpio_gate: assert property (@(posedge clock) disable iff (rst)
        gpio_shared_en |-> addr_valid && !jtag_en)
        else $error("shared pins released while jtag may be on");

    // converter side
    a_bias_before: assert property (@(posedge clock) disable iff (rst)
        conv_start |-> ##[0:1] bias_en)
        else $error("conversion without bias");
    a_two_convs: assert property (@(posedge clock) disable iff (rst)
        $rose(addr_valid) |-> $past(conv_sel))
        else $error("upper pin not converted last");
    a_start_pulse: assert property (@(posedge clock) disable iff (rst)
        conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_bias_off: assert property (@(posedge clock) disable iff (rst)
        addr_valid |-> !bias_en)
        else $error("bias left on after decision");

    // main scenarios for coverage

    c_normal: cover property (@(posedge clock) $rose(addr_valid) && !jtag_en);
    c_fallback: cover property (@(posedge clock)
        $rose(addr_valid) && bus_addr == pmad_pkg::fallback_addr);
    c_blank: cover property (@(posedge clock)
        $rose(addr_valid) && jtag_en && bus_addr != pmad_pkg::fallback_addr);
    c_reset_mid: cover property (@(posedge clock) rst && cur.st == pmad_pkg::pmad_wait_lower);
    c_stray_done: cover property (@(posedge clock) conv_valid && cur.st == pmad_pkg::pmad_done);

endmodule : pmad_decode

// ==== sim/pmad_conv_model.sv ====
/*
 * converter model for the strap decoder: answers conv_start with one conv_valid.
 * assumes the bench sets the pin codes, the latency and any stray strobe.
 */
module pmad_conv_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic bias_en,
    input wire logic conv_start,
    input wire logic conv_sel,
    input wire logic [11:0] code_lower,
    input wire logic [11:0] code_upper,
    input wire logic [3:0] lat,
    input wire logic spur,
    output logic conv_valid,
    output logic [11:0] conv_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    logic sel = 1'b0;
    logic biased = 1'b0;
    logic [3:0] cnt = 4'h0;
    initial conv_valid = 1'b0;
    initial conv_code = 12'h0_000;
    always @(posedge clock)
    begin
        conv_valid <= 1'b0;
        // stale bus toggles so an old code is never mistaken for a fresh one
        conv_code <= ~conv_code;
        if (spur)
        begin
            conv_valid <= 1'b1;
            conv_code <= code_upper;
        end
        else if (rst)
            busy <= 1'b0;
        else if (busy && cnt == 4'h0)
        begin
            busy <= 1'b0;
            conv_valid <= 1'b1;
            // no bias current means the pin reads as shorted
            conv_code <= !biased ? 12'h0_000 : (sel ? code_upper : code_lower);
        end
        else if (busy)
            cnt <= cnt - 4'h1;
        else if (conv_start)
        begin
            busy <= 1'b1;
            sel <= conv_sel;
            biased <= bias_en;
            cnt <= lat;
        end
    end
endmodule : pmad_conv_model

// ==== sim/testbench.sv ====
/*
 * testbench for the strap decoder: table of pin codes, then reset and stray-strobe cases.
 * assumes the package thresholds and the converter model beside the design.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [11:0] up; logic [11:0] lo; logic fb; logic [6:0] addr;
        logic jtag;} pmad_row_s;
    // straps avoid addresses 0, 11, 12, 127 and a permanent 126
    localparam pmad_row_s rows [10] = '{
        '{12'h0_1B5, 12'h0_A2C, 1'b0, 7'h3B, 1'b0}, '{12'h0_221, 12'h0_222, 1'b0, 7'h35, 1'b0},
        '{12'h0_2AB, 12'h0_355, 1'b0, 7'h4F, 1'b0}, '{12'h0_534, 12'h0_42B, 1'b0, 7'h68, 1'b0},
        '{12'h0_535, 12'h0_682, 1'b0, 7'h75, 1'b0}, '{12'h0_683, 12'h0_1B5, 1'b0, 7'h7C, 1'b0},
        '{12'h0_400, 12'h0_1B4, 1'b0, 7'h7E, 1'b1}, '{12'h0_A2D, 12'h0_300, 1'b0, 7'h7E, 1'b1},
        '{12'h0_355, 12'h0_822, 1'b1, 7'h5E, 1'b1}, '{12'h0_000, 12'h0_FFF, 1'b1, 7'h7E, 1'b1}};
    logic clock = 1'b0, rst = 1'b1, fb = 1'b0, spur = 1'b0;
    logic [11:0] up = 12'h0_000, lo = 12'h0_000, conv_code;
    logic [3:0] lat = 4'h0;
    logic bias_en, conv_start, conv_sel, conv_valid, jtag_en, gpio_shared_en, addr_valid;
    logic [6:0] bus_addr;
    int miscompares = 0;
    int num_checks = 0;
    initial forever #10 clock = ~clock;
    pmad_decode u_dut (.clock(clock), .rst(rst), .flash_blank(fb), .conv_valid(conv_valid),
        .conv_code(conv_code), .bias_en(bias_en), .conv_start(conv_start), .conv_sel(conv_sel),
        .bus_addr(bus_addr), .jtag_en(jtag_en), .gpio_shared_en(gpio_shared_en),
        .addr_valid(addr_valid));
    pmad_conv_model u_conv (.clock(clock), .rst(rst), .bias_en(bias_en),
        .conv_start(conv_start), .conv_sel(conv_sel), .code_lower(lo), .code_upper(up),
        .lat(lat), .spur(spur), .conv_valid(conv_valid), .conv_code(conv_code));
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic restart(input logic [11:0] u, input logic [11:0] l, input logic f,
        input logic [3:0] lt);
        @(posedge clock);
        up <= u;
        lo <= l;
        fb <= f;
        lat <= lt;
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        #1 check(addr_valid, 7'h0);
        check(gpio_shared_en, 7'h0);
        check(jtag_en, 7'h1);
        check(bus_addr, 7'h0);
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1 check({bias_en, conv_start, conv_sel}, 7'h6);
    endtask : restart
    task automatic wait_done;
        int i;
        for (i = 0; i < 100 && addr_valid !== 1'b1; i++)
            @(posedge clock) #1;
        if (addr_valid !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: no result in time", $time);
            end_of_test();
        end
    endtask : wait_done
    initial
    begin
        for (int i = 0; i < 10; i++)
        begin
            restart(rows[i].up, rows[i].lo, rows[i].fb, 4'((i % 3) * 5));
            wait_done();
            check(bus_addr, rows[i].addr);
            check(jtag_en, rows[i].jtag);
            check(gpio_shared_en, !rows[i].jtag);
            check(bias_en, 7'h0);
            $display("row %0d done", i);
        end
        // reset lands while the slow converter is still busy
        restart(12'h0_FFF, 12'h0_300, 1'b0, 4'hF);
        repeat (10) @(posedge clock);
        #1 check(addr_valid, 7'h0);
        restart(rows[0].up, rows[0].lo, 1'b0, 4'h0);
        wait_done();
        check(bus_addr, 7'h3B);
        $display("mid-run reset test done");
        // stray strobe with an open code must not refresh the result
        @(posedge clock);
        up <= 12'h0_FFF;
        spur <= 1'b1;
        @(posedge clock);
        spur <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check(bus_addr, 7'h3B);
        check({addr_valid, jtag_en}, 7'h2);
        $display("stray strobe test done");
        end_of_test();
    end
endmodule : testbench
